// ==== hw/hfr_host_port.sv ====
// serial host port, fifo, direct commands and interrupt register
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hfr_host_port
    import hfr_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [hfr_pkg::ADDR_W-1:0] BUS_ADDR,
    input wire logic [hfr_pkg::DATA_W-1:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    output logic [hfr_pkg::DATA_W-1:0] BUS_RDATA,
    input wire logic SERIAL_SELECT_LINE,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_IN_LINE,
    output logic SERIAL_OUT_LINE,
    output logic SERIAL_OUT_OE,
    output logic IRQ_OUTPUT_PIN,
    input wire logic OSC_CLK,
    input wire logic [hfr_pkg::EXT_EV_W-1:0] EVENT_IN,
    output logic [7:0] TX_DATA,
    output logic TX_VALID,
    input wire logic TX_READY,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_VALID,
    input wire logic [7:0] CONV_RESULT,
    input wire logic CONV_VALID,
    output logic [5:0] CMD_CODE,
    output logic CMD_STROBE,
    output logic TX_CRC_EN,
    output logic RX_MASKED
);
    import hfr_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic sel_m, sel_s;
    logic sclk_m, sclk_s, sclk_d;
    logic sdi_m, sdi_s;
    logic osc_m, osc_s, osc_d;
    logic sclk_rise, sclk_fall, osc_rise;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            {sel_m, sel_s, sdi_m, sdi_s} <= 4'h0;
            {sclk_m, sclk_s, sclk_d, osc_m, osc_s, osc_d} <= 6'h00;
        end else begin
            {sel_s, sel_m} <= {sel_m, SERIAL_SELECT_LINE};
            {sclk_d, sclk_s, sclk_m} <= {sclk_s, sclk_m, SERIAL_CLK};
            {sdi_s, sdi_m} <= {sdi_m, SERIAL_IN_LINE};
            {osc_d, osc_s, osc_m} <= {osc_s, osc_m, OSC_CLK};
        end
    end

    assign sclk_rise = sclk_s && !sclk_d;
    assign sclk_fall = !sclk_s && sclk_d;
    assign osc_rise = osc_s && !osc_d;

    // ------------------------------------------------------------
    // command decode helpers
    // ------------------------------------------------------------
    function automatic logic cmd_known(input logic [5:0] c);
        case (c)
            CMD_SET_DEFAULT, CMD_CLEAR, CMD_TX_CRC, CMD_TX_NOCRC,
            CMD_TX_REQA, CMD_TX_WUPA, CMD_NFC_INIT, CMD_NFC_RESP,
            CMD_NFC_RESP0, CMD_RX_MASK, CMD_RX_UNMASK, CMD_AD_CONV,
            CMD_MEAS_RF, CMD_SQUELCH, CMD_CLR_SQUELCH, CMD_ADJ_REG,
            CMD_CAL_MOD, CMD_CAL_ANT, CMD_CHK_ANT, CMD_CLR_RSSI,
            CMD_TRANSP: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction : cmd_known

    function automatic logic cmd_is_tx(input logic [5:0] c);
        cmd_is_tx = (c == CMD_TX_CRC) || (c == CMD_TX_NOCRC) ||
            (c == CMD_TX_REQA) || (c == CMD_TX_WUPA) ||
            (c == CMD_NFC_INIT) || (c == CMD_NFC_RESP) || (c == CMD_NFC_RESP0);
    endfunction : cmd_is_tx

    // ------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------
    hfr_spi_st_t st_ff, nxt_st;
    logic [2:0] bit_ff;
    logic [6:0] sh_ff;
    logic [7:0] nb;
    logic byte_done;
    logic load_wr, spi_pop, cmd_go;
    logic [5:0] cmd_code;
    logic cmd_ok;
    logic [7:0] cfg_ff;
    logic [7:0] head;
    logic [7:0] fifo_head;
    logic fifo_empty, fifo_full;
    logic [CNT_W-1:0] fifo_cnt;
    logic sdo_ff;

    assign nb = {sh_ff, sdi_s};
    assign byte_done = sel_s && sclk_fall && (bit_ff == 3'h7);
    assign cmd_code = nb[5:0];

    // header byte fixes the mode for the rest of the frame
    always_comb begin
        nxt_st = st_ff;
        if (st_ff == SP_HDR && byte_done) begin
            case (nb[7:6])
                MODE_FIFO: begin
                    if (nb[5:0] == CODE_LOAD) begin
                        nxt_st = SP_LOAD;
                    end else if (nb[5:0] == CODE_READ) begin
                        nxt_st = SP_READ;
                    end else begin
                        nxt_st = SP_IDLE;
                    end
                end
                default: nxt_st = SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff <= SP_HDR;
            bit_ff <= 3'h0;
            sh_ff <= 7'h00;
        end else if (!sel_s) begin
            // low select holds the shifter in reset; a part byte is dropped
            st_ff <= SP_HDR;
            bit_ff <= 3'h0;
            sh_ff <= 7'h00;
        end else begin
            st_ff <= nxt_st;
            if (sclk_fall) begin
                sh_ff <= nb[6:0];
                bit_ff <= bit_ff + 3'h1;
            end
        end
    end

    // whole load bytes only reach the fifo
    assign load_wr = byte_done && (st_ff == SP_LOAD);
    // a read byte is consumed only once all eight bits went out
    assign spi_pop = byte_done && (st_ff == SP_READ);
    assign cmd_go = byte_done && (st_ff == SP_HDR) && (nb[7:6] == MODE_CMD);
    // type A only frames are refused outside type A mode
    assign cmd_ok = cmd_go && cmd_known(cmd_code) &&
        (cfg_ff[CFG_TYPEA_BIT] ||
         !((cmd_code == CMD_TX_REQA) || (cmd_code == CMD_TX_WUPA)));

    assign head = fifo_empty ? 8'h00 : fifo_head;

    // output bit changes on rising serial edges, msb first
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            sdo_ff <= 1'b0;
        end else if (!sel_s) begin
            sdo_ff <= 1'b0;
        end else if (sclk_rise && st_ff == SP_READ) begin
            sdo_ff <= head[3'h7 - bit_ff];
        end
    end

    assign SERIAL_OUT_LINE = sdo_ff;
    assign SERIAL_OUT_OE = sel_s && (st_ff == SP_READ);

    // ------------------------------------------------------------
    // direct commands
    // ------------------------------------------------------------
    logic set_default, clear_cmd;
    logic tx_active_ff;
    logic rx_mask_ff;
    logic crc_ff;
    logic [5:0] code_ff;
    logic strobe_ff;

    assign set_default = cmd_ok && (cmd_code == CMD_SET_DEFAULT);
    assign clear_cmd = cmd_ok && (cmd_code == CMD_CLEAR);

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            code_ff <= 6'h00;
            strobe_ff <= 1'b0;
        end else begin
            strobe_ff <= cmd_ok;
            if (cmd_ok) begin
                code_ff <= cmd_code;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_active_ff <= 1'b0;
            crc_ff <= 1'b0;
        end else if (set_default || clear_cmd) begin
            tx_active_ff <= 1'b0;
            crc_ff <= 1'b0;
        end else if (cmd_ok && cmd_is_tx(cmd_code)) begin
            tx_active_ff <= 1'b1;
            crc_ff <= (cmd_code != CMD_TX_NOCRC);
        end else if (tx_active_ff && fifo_empty) begin
            tx_active_ff <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rx_mask_ff <= 1'b0;
        end else if (set_default) begin
            rx_mask_ff <= 1'b0;
        end else if (cmd_ok && cmd_code == CMD_RX_MASK) begin
            rx_mask_ff <= 1'b1;
        end else if (cmd_ok && cmd_code == CMD_RX_UNMASK) begin
            rx_mask_ff <= 1'b0;
        end
    end

    assign CMD_CODE = code_ff;
    assign CMD_STROBE = strobe_ff;
    assign TX_CRC_EN = crc_ff;
    assign RX_MASKED = rx_mask_ff;

    // ------------------------------------------------------------
    // fifo
    // ------------------------------------------------------------
    logic rx_wr, tx_pop, f_wr, f_rd;
    logic [7:0] f_wdata;

    assign rx_wr = RX_VALID && !tx_active_ff && !rx_mask_ff;
    assign tx_pop = TX_VALID && TX_READY;
    assign f_wr = load_wr || rx_wr;
    assign f_wdata = load_wr ? nb : RX_DATA;
    assign f_rd = spi_pop || tx_pop;

    hfr_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .CW(CNT_W)
    ) u_fifo (
        .clk(MCLK),
        .rst_n(RESETN),
        .flush(set_default || clear_cmd),
        .wr_en(f_wr),
        .wr_data(f_wdata),
        .rd_en(f_rd),
        .rd_data(fifo_head),
        .count(fifo_cnt),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // framing logic drains the fifo while a transmit runs
    assign TX_DATA = fifo_head;
    assign TX_VALID = tx_active_ff && !fifo_empty;

    // ------------------------------------------------------------
    // water level and overflow
    // ------------------------------------------------------------
    logic [5:0] tx_wl, rx_wl;
    logic tx_low_ff, rx_high_ff, ovf_ff;
    logic tx_low, rx_high, wl_ev, ovf_ev;

    assign tx_wl = cfg_ff[CFG_TXWL_BIT] ? TX_WL_HI : TX_WL_LO;
    assign rx_wl = cfg_ff[CFG_RXWL_BIT] ? RX_WL_HI : RX_WL_LO;
    assign tx_low = fifo_cnt < tx_wl;
    assign rx_high = fifo_cnt > rx_wl;
    assign wl_ev = tx_active_ff ? (tx_low && !tx_low_ff)
                                : (rx_high && !rx_high_ff);
    assign ovf_ev = rx_wr && fifo_full;

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            tx_low_ff <= 1'b1;
            rx_high_ff <= 1'b0;
        end else begin
            tx_low_ff <= tx_low;
            rx_high_ff <= rx_high;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ovf_ff <= 1'b0;
        end else if (ovf_ev) begin
            ovf_ff <= 1'b1;
        end else if (set_default || clear_cmd) begin
            ovf_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers and interrupt
    // ------------------------------------------------------------
    logic [7:0] irq_ff, mask_ff, conv_ff, rdata_ff, irq_set;
    logic clr_pend_ff, clr_now;

    assign irq_set = {EVENT_IN, ovf_ev, wl_ev};
    // oscillator edges time the clear, except initial target mode
    assign clr_now = clr_pend_ff && (cfg_ff[CFG_TGT_BIT] ? sclk_rise : osc_rise);

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            clr_pend_ff <= 1'b0;
        end else if (BUS_RD && BUS_ADDR == REG_IRQ) begin
            clr_pend_ff <= 1'b1;
        end else if (clr_now || set_default || clear_cmd) begin
            clr_pend_ff <= 1'b0;
        end
    end

    // new events are kept even in the cycle the clear lands
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_ff <= 8'h00;
        end else if (clr_now || set_default || clear_cmd) begin
            irq_ff <= irq_set;
        end else begin
            irq_ff <= irq_ff | irq_set;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_ff <= MASK_RESET;
            cfg_ff <= CFG_RESET;
        end else if (set_default) begin
            mask_ff <= MASK_RESET;
            cfg_ff <= CFG_RESET;
        end else if (BUS_WR) begin
            if (BUS_ADDR == REG_MASK) begin
                mask_ff <= BUS_WDATA;
            end
            if (BUS_ADDR == REG_CFG) begin
                cfg_ff <= BUS_WDATA;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            conv_ff <= 8'h00;
        end else if (set_default) begin
            conv_ff <= 8'h00;
        end else if (CONV_VALID) begin
            conv_ff <= CONV_RESULT;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            rdata_ff <= 8'h00;
        end else if (BUS_RD) begin
            case (BUS_ADDR)
                REG_IRQ: rdata_ff <= irq_ff;
                REG_MASK: rdata_ff <= mask_ff;
                REG_CFG: rdata_ff <= cfg_ff;
                REG_FSTAT: rdata_ff <= {1'b0, ovf_ff, fifo_cnt};
                REG_CONV: rdata_ff <= conv_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign BUS_RDATA = rdata_ff;
    assign IRQ_OUTPUT_PIN = |(irq_ff & ~mask_ff);
endmodule : hfr_host_port
`default_nettype wire

// ==== hw/hfr_pkg.sv ====
// shared constants of the reader front end host port
package hfr_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W = 6;

    // register map
    localparam logic [2:0] REG_IRQ = 3'h0;
    localparam logic [2:0] REG_MASK = 3'h1;
    localparam logic [2:0] REG_CFG = 3'h2;
    localparam logic [2:0] REG_FSTAT = 3'h3;
    localparam logic [2:0] REG_CONV = 3'h4;

    // interrupt bits; bits 7:2 are external event sources
    localparam int IRQ_WL_BIT = 0;
    localparam int IRQ_OVF_BIT = 1;
    localparam int EXT_EV_LSB = 2;
    localparam int EXT_EV_W = 6;

    // configuration bits
    localparam int CFG_TXWL_BIT = 0;
    localparam int CFG_RXWL_BIT = 1;
    localparam int CFG_TYPEA_BIT = 2;
    localparam int CFG_TGT_BIT = 3;
    localparam logic [7:0] CFG_RESET = 8'h04;
    localparam logic [7:0] MASK_RESET = 8'h00;

    // water levels, two settings each
    localparam logic [5:0] TX_WL_LO = 6'h08;
    localparam logic [5:0] TX_WL_HI = 6'h10;
    localparam logic [5:0] RX_WL_LO = 6'h10;
    localparam logic [5:0] RX_WL_HI = 6'h18;

    // serial mode bits and fifo codes
    localparam logic [1:0] MODE_FIFO = 2'b10;
    localparam logic [1:0] MODE_CMD = 2'b11;
    localparam logic [5:0] CODE_LOAD = 6'h00;
    localparam logic [5:0] CODE_READ = 6'h3f;

    // direct command codes
    localparam logic [5:0] CMD_SET_DEFAULT = 6'h01;
    localparam logic [5:0] CMD_CLEAR = 6'h02;
    localparam logic [5:0] CMD_TX_CRC = 6'h04;
    localparam logic [5:0] CMD_TX_NOCRC = 6'h05;
    localparam logic [5:0] CMD_TX_REQA = 6'h06;
    localparam logic [5:0] CMD_TX_WUPA = 6'h07;
    localparam logic [5:0] CMD_NFC_INIT = 6'h08;
    localparam logic [5:0] CMD_NFC_RESP = 6'h09;
    localparam logic [5:0] CMD_NFC_RESP0 = 6'h0a;
    localparam logic [5:0] CMD_RX_MASK = 6'h10;
    localparam logic [5:0] CMD_RX_UNMASK = 6'h11;
    localparam logic [5:0] CMD_AD_CONV = 6'h12;
    localparam logic [5:0] CMD_MEAS_RF = 6'h13;
    localparam logic [5:0] CMD_SQUELCH = 6'h14;
    localparam logic [5:0] CMD_CLR_SQUELCH = 6'h15;
    localparam logic [5:0] CMD_ADJ_REG = 6'h16;
    localparam logic [5:0] CMD_CAL_MOD = 6'h17;
    localparam logic [5:0] CMD_CAL_ANT = 6'h18;
    localparam logic [5:0] CMD_CHK_ANT = 6'h19;
    localparam logic [5:0] CMD_CLR_RSSI = 6'h1a;
    localparam logic [5:0] CMD_TRANSP = 6'h1c;

    typedef enum logic [1:0] {SP_HDR, SP_LOAD, SP_READ, SP_IDLE} hfr_spi_st_t;
endpackage : hfr_pkg

// ==== hw/hfr_fifo.sv ====
// byte fifo shared by transmit and receive paths
`timescale 1ns/1ps
`default_nettype none
module hfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int CW = 6
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic rd_en,
    output logic [WIDTH-1:0] rd_data,
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [CW-1:0] cnt_ff;
    logic do_wr;
    logic do_rd;

    assign full = (cnt_ff == CW'(DEPTH));
    assign empty = (cnt_ff == '0);
    // a write into a full fifo is dropped, a read of an empty one too
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;
    assign rd_data = mem[rp_ff];
    assign count = cnt_ff;

    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wp_ff] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else if (flush) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (do_wr) begin
                wp_ff <= (wp_ff == AW'(DEPTH - 1)) ? '0 : wp_ff + 1'b1;
            end
            if (do_rd) begin
                rp_ff <= (rp_ff == AW'(DEPTH - 1)) ? '0 : rp_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + CW'(do_wr) - CW'(do_rd);
        end
    end
endmodule : hfr_fifo
`default_nettype wire

// ==== verification/hfr_port_monitor.sv ====
// checker for the host port outputs
`timescale 1ns/1ps
`default_nettype none
module hfr_port_monitor
    import hfr_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic [hfr_pkg::ADDR_W-1:0] BUS_ADDR,
    input wire logic [hfr_pkg::DATA_W-1:0] BUS_WDATA,
    input wire logic BUS_WR,
    input wire logic BUS_RD,
    input wire logic [hfr_pkg::DATA_W-1:0] BUS_RDATA,
    input wire logic SERIAL_SELECT_LINE,
    input wire logic SERIAL_CLK,
    input wire logic SERIAL_OUT_LINE,
    input wire logic SERIAL_OUT_OE,
    input wire logic IRQ_OUTPUT_PIN,
    input wire logic [hfr_pkg::EXT_EV_W-1:0] EVENT_IN,
    input wire logic [5:0] CMD_CODE,
    input wire logic CMD_STROBE
);
    default clocking @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    // shadow of the mask register, so masked events can be told apart
    logic [7:0] mask_ff;
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            mask_ff <= MASK_RESET;
        end else if (BUS_WR && BUS_ADDR == REG_MASK) begin
            mask_ff <= BUS_WDATA;
        end
    end
    sequence irq_read;
        BUS_RD && BUS_ADDR == REG_IRQ;
    endsequence
    sequence quiet_8;
        (EVENT_IN == 6'h00) [*8];
    endsequence
    rd_idle_a: assert property (!BUS_RD |=> BUS_RDATA == 8'h00)
        else $error("read data left standing");
    fifo_count_a: assert property (BUS_RD && BUS_ADDR == REG_FSTAT
        |=> BUS_RDATA[5:0] <= 6'h20 && !BUS_RDATA[7]) else $error("fifo count out of range");
    ev_raise_a: assert property (|(EVENT_IN & ~mask_ff[7:2])
        |-> ##[1:2] IRQ_OUTPUT_PIN) else $error("interrupt pin not raised");
    masked_quiet_a: assert property (mask_ff == 8'hff |-> !IRQ_OUTPUT_PIN)
        else $error("masked source raised the pin");
    irq_clear_a: assert property (irq_read ##1 quiet_8 |-> ##[1:40] !IRQ_OUTPUT_PIN)
        else $error("interrupt not cleared after read");
    cmd_known_a: assert property (CMD_STROBE |-> CMD_CODE inside
        {[6'h01:6'h02], [6'h04:6'h0a], [6'h10:6'h1a], 6'h1c}) else $error("unknown code run");
    cmd_pulse_a: assert property (CMD_STROBE |=> !CMD_STROBE)
        else $error("command strobe too long");
    oe_drop_a: assert property ($fell(SERIAL_SELECT_LINE) |-> ##[0:4] !SERIAL_OUT_OE)
        else $error("output enable kept after select");
    out_edge_a: assert property (SERIAL_OUT_OE && $past(SERIAL_OUT_OE) && SERIAL_SELECT_LINE
        && $changed(SERIAL_OUT_LINE) |-> SERIAL_CLK) else $error("output moved on falling edge");
endmodule : hfr_port_monitor
bind hfr_host_port hfr_port_monitor u_mon (.MCLK, .RESETN, .BUS_ADDR, .BUS_WDATA, .BUS_WR,
    .BUS_RD, .BUS_RDATA, .SERIAL_SELECT_LINE, .SERIAL_CLK, .SERIAL_OUT_LINE, .SERIAL_OUT_OE,
    .IRQ_OUTPUT_PIN, .EVENT_IN, .CMD_CODE, .CMD_STROBE);
`default_nettype wire

// ==== verification/hfr_host_model.sv ====
// serial bus master standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module hfr_host_model (
    output logic sel,
    output logic sclk,
    output logic sdi,
    input wire logic sdo
);
    // 80 ns period keeps each half well above the port's synchroniser need
    localparam int HALF = 40;
    initial begin
        sel = 1'b0;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    task automatic open_frame;
        #1;
        sel = 1'b1;
        #HALF;
    endtask : open_frame
    // msb first; nbits below 8 cuts the byte short
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i >= 8 - nbits; i--) begin
            sclk = 1'b1;
            sdi = tx[i];
            #HALF;
            sclk = 1'b0;
            rx[i] = sdo;
            #HALF;
        end
        // the line is not held after the byte, so show the inverse
        sdi = ~sdi;
    endtask : xfer
    task automatic close_frame;
        sel = 1'b0;
        #(4 * HALF);
    endtask : close_frame
endmodule : hfr_host_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import hfr_pkg::*;
    typedef struct packed {logic wr; logic [2:0] a; logic [7:0] d;} hfr_row_t;
    logic MCLK = 0, RESETN = 0, BUS_WR = 0, BUS_RD = 0, OSC_CLK = 0, TX_READY = 0;
    logic RX_VALID = 0, CONV_VALID = 0, SERIAL_SELECT_LINE, SERIAL_CLK, SERIAL_IN_LINE;
    logic [2:0] BUS_ADDR = 0;
    logic [7:0] BUS_WDATA = 0, RX_DATA = 0, CONV_RESULT = 0, BUS_RDATA, TX_DATA, rx, v;
    logic [5:0] EVENT_IN = 0, CMD_CODE, seen_code;
    logic SERIAL_OUT_LINE, SERIAL_OUT_OE, IRQ_OUTPUT_PIN, TX_VALID, CMD_STROBE;
    logic TX_CRC_EN, RX_MASKED;
    int err_count = 0, compares = 0, n_strobe = 0;
    logic [5:0] codes [20] = '{CMD_CLEAR, CMD_TX_CRC, CMD_TX_NOCRC, CMD_TX_REQA, CMD_TX_WUPA,
        CMD_NFC_INIT, CMD_NFC_RESP, CMD_NFC_RESP0, CMD_RX_MASK, CMD_RX_UNMASK, CMD_AD_CONV,
        CMD_MEAS_RF, CMD_SQUELCH, CMD_CLR_SQUELCH, CMD_ADJ_REG, CMD_CAL_MOD, CMD_CAL_ANT,
        CMD_CHK_ANT, CMD_CLR_RSSI, CMD_TRANSP};
    hfr_row_t rows [11] = '{'{0, REG_CFG, CFG_RESET}, '{0, REG_MASK, MASK_RESET},
        '{1, REG_MASK, 8'ha5}, '{0, REG_MASK, 8'ha5}, '{1, REG_MASK, 8'h00},
        '{1, REG_FSTAT, 8'h1f}, '{0, REG_FSTAT, 8'h00}, '{1, REG_CONV, 8'h77},
        '{0, REG_CONV, 8'h00}, '{0, 3'h7, 8'h00}, '{0, REG_IRQ, 8'h00}};
    always #2 MCLK = ~MCLK;
    always #36.873 OSC_CLK = ~OSC_CLK;
    always @(posedge MCLK) if (CMD_STROBE === 1'b1) begin
        seen_code <= CMD_CODE;
        n_strobe <= n_strobe + 1;
    end
    hfr_host_model host (.sel(SERIAL_SELECT_LINE), .sclk(SERIAL_CLK), .sdi(SERIAL_IN_LINE),
        .sdo(SERIAL_OUT_LINE));
    hfr_host_port dut (.MCLK, .RESETN, .BUS_ADDR, .BUS_WDATA, .BUS_WR, .BUS_RD, .BUS_RDATA,
        .SERIAL_SELECT_LINE, .SERIAL_CLK, .SERIAL_IN_LINE, .SERIAL_OUT_LINE, .SERIAL_OUT_OE,
        .IRQ_OUTPUT_PIN, .OSC_CLK, .EVENT_IN, .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA,
        .RX_VALID, .CONV_RESULT, .CONV_VALID, .CMD_CODE, .CMD_STROBE, .TX_CRC_EN, .RX_MASKED);
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge MCLK);
        BUS_WR <= 1'b1;
        BUS_ADDR <= a;
        BUS_WDATA <= d;
        @(posedge MCLK);
        BUS_WR <= 1'b0;
    endtask : bus_wr
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge MCLK);
        BUS_RD <= 1'b1;
        BUS_ADDR <= a;
        @(posedge MCLK);
        BUS_RD <= 1'b0;
        #1 check("register", exp, BUS_RDATA);
    endtask : rd_chk
    task automatic pulse(input logic [2:0] k, input logic [5:0] ev);
        @(posedge MCLK);
        {TX_READY, RX_VALID, CONV_VALID} <= k;
        EVENT_IN <= ev;
        @(posedge MCLK);
        {TX_READY, RX_VALID, CONV_VALID} <= 3'h0;
        EVENT_IN <= 6'h00;
    endtask : pulse
    task automatic wait_irq(input logic lvl);
        for (int i = 0; IRQ_OUTPUT_PIN !== lvl; i++) begin
            if (i == 100) begin
                check("irq pin", {7'h0, lvl}, {7'h0, IRQ_OUTPUT_PIN});
                print_verdict();
            end
            @(posedge MCLK);
        end
    endtask : wait_irq
    task automatic spi_cmd(input logic [5:0] c);
        host.open_frame();
        host.xfer({MODE_CMD, c}, 8, rx);
        host.close_frame();
    endtask : spi_cmd
    task automatic load(input int n, input logic [7:0] base);
        host.open_frame();
        host.xfer({MODE_FIFO, CODE_LOAD}, 8, rx);
        for (int i = 0; i < n; i++) host.xfer(base + 8'(i), 8, rx);
        host.close_frame();
    endtask : load
    initial begin
        repeat (4) @(posedge MCLK);
        RESETN <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) bus_wr(rows[i].a, rows[i].d);
            else rd_chk(rows[i].a, rows[i].d);
        end
        $display("register table done");
        load(3, 8'h5a);
        rd_chk(REG_FSTAT, 8'h03);
        host.open_frame();
        host.xfer({MODE_FIFO, CODE_LOAD}, 8, rx);
        host.xfer(8'hff, 4, rx);
        host.close_frame();
        rd_chk(REG_FSTAT, 8'h03);
        host.open_frame();
        host.xfer({MODE_FIFO, CODE_READ}, 8, rx);
        host.xfer(8'h00, 8, v);
        check("fifo byte", 8'h5a, v);
        host.xfer(8'h00, 4, v);
        host.close_frame();
        host.open_frame();
        host.xfer({MODE_FIFO, CODE_READ}, 8, rx);
        host.xfer(8'h00, 8, v);
        check("fifo byte", 8'h5b, v);
        host.close_frame();
        rd_chk(REG_FSTAT, 8'h01);
        spi_cmd(CMD_CLEAR);
        rd_chk(REG_FSTAT, 8'h00);
        $display("fifo load and read done");
        load(10, 8'h30);
        spi_cmd(CMD_TX_CRC);
        check("crc enable", 8'h01, {7'h0, TX_CRC_EN});
        for (int i = 0; i < 10; i++) begin
            check("tx data", 8'h30 + 8'(i), TX_DATA);
            pulse(3'h4, 6'h00);
            #1;
        end
        check("tx valid", 8'h00, {7'h0, TX_VALID});
        wait_irq(1'b1);
        rd_chk(REG_IRQ, 8'h01);
        wait_irq(1'b0);
        $display("transmit done");
        for (int i = 0; i < 33; i++) begin
            RX_DATA <= 8'(i);
            pulse(3'h2, 6'h00);
        end
        rd_chk(REG_FSTAT, 8'h60);
        rd_chk(REG_IRQ, 8'h03);
        wait_irq(1'b0);
        rd_chk(REG_IRQ, 8'h00);
        // a clear still pending from the read would wipe the event
        repeat (40) @(posedge MCLK);
        pulse(3'h0, 6'h01);
        wait_irq(1'b1);
        rd_chk(REG_IRQ, 8'h04);
        wait_irq(1'b0);
        bus_wr(REG_MASK, 8'hff);
        pulse(3'h0, 6'h20);
        repeat (5) @(posedge MCLK);
        check("irq pin", 8'h00, {7'h0, IRQ_OUTPUT_PIN});
        rd_chk(REG_IRQ, 8'h80);
        bus_wr(REG_MASK, 8'h00);
        CONV_RESULT <= 8'h9c;
        pulse(3'h1, 6'h00);
        rd_chk(REG_CONV, 8'h9c);
        $display("interrupts done");
        foreach (codes[i]) begin
            spi_cmd(codes[i]);
            check("command code", {2'b00, codes[i]}, {2'b00, seen_code});
            if (codes[i] == CMD_TX_NOCRC) check("crc", 8'h00, {7'h0, TX_CRC_EN});
            if (codes[i] == CMD_RX_MASK) check("masked", 8'h01, {7'h0, RX_MASKED});
        end
        check("rx masked", 8'h00, {7'h0, RX_MASKED});
        spi_cmd(6'h03);
        spi_cmd(6'h1b);
        check("strobe count", 8'h16, 8'(n_strobe));
        bus_wr(REG_CFG, 8'h0b);
        spi_cmd(CMD_TX_WUPA);
        check("strobe count", 8'h16, 8'(n_strobe));
        spi_cmd(CMD_SET_DEFAULT);
        rd_chk(REG_CFG, CFG_RESET);
        $display("commands done");
        print_verdict();
    end
endmodule : tb
`default_nettype wire
